// ==== rpm_pkg.sv ====
package rpm_pkg;
  localparam int NUM_BUCK = 3;
  localparam int NUM_SWITCH = 3;
  localparam int NUM_EXTREG = 2;
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_SHORT_US = 50;
  localparam int DEBOUNCE_LONG_US = 100;
  localparam int DEBOUNCE_SHORT_CYC = DEBOUNCE_SHORT_US * CLK_MHZ;
  localparam int DEBOUNCE_LONG_CYC = DEBOUNCE_LONG_US * CLK_MHZ;
  localparam int DEBOUNCE_W = 14;
  localparam logic DEBOUNCE_SEL_RST = 1'b1;
  localparam logic [1:0] THRESH_SEL_RST = 2'h0;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_OPMODE = 12'h004;
  localparam logic [11:0] ADDR_ASSIGN = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h010;
  localparam logic [11:0] ADDR_INT_MASK = 12'h014;
  // deep sleep on, 100 us debounce, lowest threshold code, holdup on
  localparam logic [31:0] CTRL_RST = 32'h0000_0013;
  localparam logic [31:0] OPMODE_RST = 32'h0000_0000;
  localparam logic [31:0] ASSIGN_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0001;
  localparam int CTRL_DEEP_SLEEP = 0;
  localparam int CTRL_DBNC_SEL = 1;
  localparam int CTRL_THRESH_LO = 2;
  localparam int CTRL_HOLDUP_EN = 4;
  localparam int CTRL_SLEEP_VSCALE = 5;

  typedef enum logic [1:0] {
    RPM_OFF,
    RPM_NORMAL,
    RPM_LOW
  } rpm_power_type;
endpackage

// ==== rpm_reg_decode.sv ====
`timescale 1ns/1ps
module rpm_reg_decode
  import rpm_pkg::*;
(
  rpm_reg_if.dec port,
  input wire logic sleepVscaleOtp
);
  rpm_power_type pwr;
  logic lowSleep;

  always_comb begin
    lowSleep = 1'b0;
    if (port.assigned && !port.seqEnable) begin
      pwr = RPM_OFF;
    end else begin
      case (port.opMode)
        2'h0: pwr = RPM_OFF;
        2'h1: begin
          // assigned path: deep-sleep column ambiguous; normal power chosen
          if (!port.assigned && port.deepSleep) begin
            pwr = RPM_LOW;
            lowSleep = 1'b1;
          end else begin
            pwr = RPM_NORMAL;
          end
        end
        2'h2: pwr = RPM_LOW;
        default: pwr = RPM_NORMAL;
      endcase
    end
  end

  assign port.enable = (pwr != RPM_OFF);
  assign port.lowPower = (pwr == RPM_LOW);
  assign port.sleepScale = lowSleep & sleepVscaleOtp;
endmodule

// ==== rpm_reg_if.sv ====
`timescale 1ns/1ps
interface rpm_reg_if;
  logic [1:0] opMode;
  logic assigned;
  logic seqEnable;
  logic deepSleep;
  logic enable;
  logic lowPower;
  logic sleepScale;
  modport ctrl (output opMode, output assigned, output seqEnable, output deepSleep,
    input enable, input lowPower, input sleepScale);
  modport dec (input opMode, input assigned, input seqEnable, input deepSleep,
    output enable, output lowPower, output sleepScale);
endinterface

// ==== rpm_resource_power_mode_decode.sv ====
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module rpm_resource_power_mode_decode
  import rpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_BUCK-1:0] seq_enable_buck,
  input wire logic seq_enable_linreg,
  input wire logic [NUM_SWITCH-1:0] seq_enable_switch,
  input wire logic [NUM_EXTREG-1:0] seq_enable_extreg,
  input wire logic overcurrentCompare,
  output logic [NUM_BUCK-1:0] buckEnableOut,
  output logic [NUM_BUCK-1:0] buck_low_power_en,
  output logic linreg_enable_out,
  output logic linreg_low_power_en,
  output logic third_buck_sleep_vscale,
  output logic [NUM_SWITCH-1:0] switch_enable_out,
  output logic [NUM_EXTREG-1:0] extreg_enable_pin,
  output logic [1:0] overcurrent_threshold_sel,
  output logic holdupEnableOut,
  output logic powerDownReq,
  output logic irq
);
  localparam int NUM_REG = NUM_BUCK + 1;

  logic [31:0] ctrl_r;
  logic [31:0] opMode_r;
  logic [31:0] assign_r;
  logic intStatus_r;
  logic intMask_r;
  logic wrPend_r;
  logic rdPend_r;
  logic [11:0] addr_r;
  logic [2:0] ocSync_r;
  logic ocLevel_r;
  logic [DEBOUNCE_W-1:0] dbnc_r;
  logic ocEvent;
  logic [DEBOUNCE_W-1:0] dbncLimit;
  logic [NUM_REG-1:0] regEn;
  logic [NUM_REG-1:0] regLp;
  logic [NUM_REG-1:0] regScale;
  logic [NUM_REG-1:0] regSeq;

  assign regSeq = {seq_enable_linreg, seq_enable_buck};

  // buck i and linear regulator share one decoder type
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REG; gi++) begin : g_reg
      rpm_reg_if rif ();
      assign rif.opMode = opMode_r[2*gi+1 -: 2];
      assign rif.assigned = assign_r[gi];
      assign rif.seqEnable = regSeq[gi];
      assign rif.deepSleep = ctrl_r[CTRL_DEEP_SLEEP];
      assign regEn[gi] = rif.enable;
      assign regLp[gi] = rif.lowPower;
      assign regScale[gi] = rif.sleepScale;
      rpm_reg_decode u_dec (
        .port(rif.dec),
        .sleepVscaleOtp(ctrl_r[CTRL_SLEEP_VSCALE])
      );
    end
  endgenerate

  // registered outputs keep pins glitch-free across decode changes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buckEnableOut <= '0;
      buck_low_power_en <= '0;
      linreg_enable_out <= 1'b0;
      linreg_low_power_en <= 1'b0;
      third_buck_sleep_vscale <= 1'b0;
    end else begin
      buckEnableOut <= regEn[NUM_BUCK-1:0];
      buck_low_power_en <= regLp[NUM_BUCK-1:0];
      linreg_enable_out <= regEn[NUM_BUCK];
      linreg_low_power_en <= regLp[NUM_BUCK];
      third_buck_sleep_vscale <= regScale[NUM_BUCK-1];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_enable_out <= '0;
    end else begin
      for (int i = 0; i < NUM_SWITCH; i++) begin
        if (assign_r[NUM_REG+i]) begin
          switch_enable_out[i] <= seq_enable_switch[i];
        end else begin
          switch_enable_out[i] <= opMode_r[8+i];
        end
      end
    end
  end

  // assignment bits are expected stable while outputs are on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extreg_enable_pin <= '0;
    end else begin
      for (int i = 0; i < NUM_EXTREG; i++) begin
        if (assign_r[NUM_REG+NUM_SWITCH+i]) begin
          extreg_enable_pin[i] <= seq_enable_extreg[i] ^ opMode_r[12+i];
        end else begin
          extreg_enable_pin[i] <= opMode_r[12+i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overcurrent_threshold_sel <= THRESH_SEL_RST;
      holdupEnableOut <= 1'b1;
    end else begin
      overcurrent_threshold_sel <= ctrl_r[CTRL_THRESH_LO +: 2];
      holdupEnableOut <= ctrl_r[CTRL_HOLDUP_EN];
    end
  end

  // comparator output is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ocSync_r <= '0;
      ocLevel_r <= 1'b0;
    end else begin
      ocSync_r <= {ocSync_r[1:0], overcurrentCompare};
      if (ocSync_r[1] == ocSync_r[2]) begin
        ocLevel_r <= ocSync_r[2];
      end
    end
  end

  assign dbncLimit = ctrl_r[CTRL_DBNC_SEL] ? DEBOUNCE_W'(DEBOUNCE_LONG_CYC)
                                           : DEBOUNCE_W'(DEBOUNCE_SHORT_CYC);
  assign ocEvent = ocLevel_r && (dbnc_r == dbncLimit - DEBOUNCE_W'(1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbnc_r <= '0;
    end else if (!ocLevel_r) begin
      dbnc_r <= '0;
    end else if (dbnc_r < dbncLimit) begin
      dbnc_r <= dbnc_r + DEBOUNCE_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerDownReq <= 1'b0;
      irq <= 1'b0;
    end else begin
      powerDownReq <= ocEvent && !intMask_r;
      irq <= intStatus_r && !intMask_r;
    end
  end

  // ahb-lite slave, zero wait states
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      addr_r <= '0;
    end else if (hready) begin
      wrPend_r <= hsel && htrans[1] && hwrite;
      rdPend_r <= hsel && htrans[1] && !hwrite;
      addr_r <= haddr[11:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      opMode_r <= OPMODE_RST;
      assign_r <= ASSIGN_RST;
      intMask_r <= MASK_RST[0];
    end else if (wrPend_r) begin
      case (addr_r)
        ADDR_CTRL: ctrl_r <= {26'h0, hwdata[5:0]};
        ADDR_OPMODE: opMode_r <= {18'h0, hwdata[13:0]};
        ADDR_ASSIGN: assign_r <= {23'h0, hwdata[8:0]};
        ADDR_INT_MASK: intMask_r <= hwdata[0];
        default: ;
      endcase
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      intStatus_r <= 1'b0;
    end else if (ocEvent) begin
      intStatus_r <= 1'b1;
    end else if (wrPend_r && addr_r == ADDR_INT_STATUS && hwdata[0]) begin
      intStatus_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        ADDR_CTRL: hrdata <= ctrl_r;
        ADDR_OPMODE: hrdata <= opMode_r;
        ADDR_ASSIGN: hrdata <= assign_r;
        ADDR_STATUS: hrdata <= {15'h0, ocLevel_r, 3'h0, extreg_enable_pin,
                                switch_enable_out, linreg_low_power_en,
                                buck_low_power_en, linreg_enable_out, buckEnableOut};
        ADDR_INT_STATUS: hrdata <= {31'h0, intStatus_r};
        ADDR_INT_MASK: hrdata <= {31'h0, intMask_r};
        default: hrdata <= '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

// ==== rpm_resource_power_mode_decode_bench.sv ====
`timescale 1ns/1ps
module rpm_resource_power_mode_decode_bench import rpm_pkg::*;;
  logic ref_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hsel = 1'b0, ocReq = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, m;
  logic [8:0] seqReq = 9'h000, seqAll, s;
  logic ocLevel, hreadyout, irq, d, rdPend = 1'b0;
  logic [31:0] rdQ[$];
  logic irqQ[$];
  int mismatches = 0, checks_done = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  rpm_seq_model i_seq (.ref_clk(ref_clk), .seqReq(seqReq), .ocReq(ocReq), .seqAll(seqAll),
    .ocLevel(ocLevel));
  rpm_resource_power_mode_decode i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .seq_enable_buck(seqAll[2:0]), .seq_enable_linreg(seqAll[3]),
    .seq_enable_switch(seqAll[6:4]), .seq_enable_extreg(seqAll[8:7]),
    .overcurrentCompare(ocLevel), .buckEnableOut(), .buck_low_power_en(),
    .linreg_enable_out(), .linreg_low_power_en(), .third_buck_sleep_vscale(),
    .switch_enable_out(), .extreg_enable_pin(), .overcurrent_threshold_sel(),
    .holdupEnableOut(), .powerDownReq(), .irq(irq));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic chk_rd(input logic [31:0] e);
    checks_done++;
    if (hrdata !== e) begin
      mismatches++;
      $display("[FAIL] %0t read %h expected %h", $time, hrdata, e);
    end
  endtask
  task automatic chk_irq(input logic e);
    checks_done++;
    if (irq !== e) begin
      mismatches++;
      $display("[FAIL] %0t irq %b expected %b", $time, irq, e);
    end
  endtask
  function automatic logic [31:0] stat(input logic [1:0] md, input logic a, input logic [8:0] q,
    input logic dp);
    logic [31:0] r;
    logic en;
    r = 32'h0;
    for (int i = 0; i < 4; i++) begin
      en = (md != 2'h0) && !(a && !q[i]);
      r[i] = en;
      r[4+i] = en && (md == 2'h2 || (md == 2'h1 && !a && dp));
    end
    for (int i = 0; i < 3; i++) r[8+i] = a ? q[4+i] : md[0];
    for (int i = 0; i < 2; i++) r[11+i] = a ? q[7+i] ^ md[0] : md[0];
    return r;
  endfunction
  // results are compared as they appear, oldest note first
  always @(posedge ref_clk) begin
    if (rdPend && rdQ.size() > 0) chk_rd(rdQ.pop_front());
    if (irqQ.size() > 0) chk_irq(irqQ.pop_front());
    rdPend <= hsel && htrans[1] && hreadyout && !hwrite;
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h68b4));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_OPMODE, OPMODE_RST);
    rd(ADDR_ASSIGN, ASSIGN_RST);
    rd(ADDR_INT_MASK, MASK_RST);
    bus(1'b1, 12'h020, 32'hffff_ffff);
    rd(12'h020, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    $display("reset and map test done");
    for (int a = 0; a < 2; a++) begin
      bus(1'b1, ADDR_OPMODE, 32'h0);
      bus(1'b1, ADDR_ASSIGN, a ? 32'h1ff : 32'h0);
      for (int k = 0; k < 16; k++) begin
        m = k[1:0];
        d = k[2];
        s = 9'($urandom);
        seqReq <= s;
        bus(1'b1, ADDR_CTRL, 32'h32 | 32'(d));
        bus(1'b1, ADDR_OPMODE, {18'h0, {2{m[0]}}, 1'b0, {3{m[0]}}, {4{m}}});
        rd(ADDR_STATUS, stat(m, a[0], s, d));
      end
      $display("decode test done, assigned %0d", a);
    end
    bus(1'b1, ADDR_INT_MASK, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h10);
    ocReq <= 1'b1;
    repeat (DEBOUNCE_SHORT_CYC - 100) @(posedge ref_clk);
    ocReq <= 1'b0;
    repeat (10) @(posedge ref_clk);
    ocReq <= 1'b1;
    repeat (DEBOUNCE_SHORT_CYC / 2) @(posedge ref_clk);
    rd(ADDR_INT_STATUS, 32'h0);
    repeat (DEBOUNCE_SHORT_CYC / 2 + 30) @(posedge ref_clk);
    rd(ADDR_INT_STATUS, 32'h1);
    irqQ.push_back(1'b1);
    ocReq <= 1'b0;
    bus(1'b1, ADDR_INT_STATUS, 32'h1);
    rd(ADDR_INT_STATUS, 32'h0);
    irqQ.push_back(1'b0);
    $display("unmasked overcurrent test done");
    bus(1'b1, ADDR_INT_MASK, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h12);
    ocReq <= 1'b1;
    repeat (DEBOUNCE_SHORT_CYC + 50) @(posedge ref_clk);
    rd(ADDR_INT_STATUS, 32'h0);
    repeat (DEBOUNCE_SHORT_CYC) @(posedge ref_clk);
    rd(ADDR_INT_STATUS, 32'h1);
    irqQ.push_back(1'b0);
    ocReq <= 1'b0;
    bus(1'b1, ADDR_INT_STATUS, 32'h1);
    rd(ADDR_INT_STATUS, 32'h0);
    $display("masked overcurrent test done");
    repeat (3) @(posedge ref_clk);
    give_verdict();
  end
endmodule

// ==== rpm_resource_power_mode_decode_props.sv ====
`timescale 1ns/1ps
module rpm_resource_power_mode_decode_props
  import rpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [NUM_BUCK-1:0] seq_enable_buck,
  input wire logic seq_enable_linreg,
  input wire logic [NUM_SWITCH-1:0] seq_enable_switch,
  input wire logic [NUM_EXTREG-1:0] seq_enable_extreg,
  input wire logic overcurrentCompare,
  input wire logic [NUM_BUCK-1:0] buckEnableOut,
  input wire logic [NUM_BUCK-1:0] buck_low_power_en,
  input wire logic linreg_enable_out,
  input wire logic linreg_low_power_en,
  input wire logic third_buck_sleep_vscale,
  input wire logic [NUM_SWITCH-1:0] switch_enable_out,
  input wire logic [NUM_EXTREG-1:0] extreg_enable_pin,
  input wire logic [1:0] overcurrent_threshold_sel,
  input wire logic holdupEnableOut,
  input wire logic powerDownReq,
  input wire logic irq
);
  logic [31:0] ctrlS, opS, asgS;
  logic maskS, wPend;
  logic [11:0] wAdr;
  logic [13:0] ocRun;
  logic [8:0] seqV;
  logic [3:0] enE, lpE;
  logic [2:0] swE;
  logic [1:0] exE;
  logic vsE;
  int dbnc;
  // shadow of the writable registers, landing on the same edge as the design's
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlS <= CTRL_RST;
      opS <= OPMODE_RST;
      asgS <= ASSIGN_RST;
      maskS <= 1'b1;
      wPend <= 1'b0;
      wAdr <= 12'h000;
    end else begin
      wPend <= hsel && htrans[1] && hready && hwrite;
      wAdr <= haddr[11:0];
      if (wPend && wAdr == ADDR_CTRL) ctrlS <= hwdata;
      if (wPend && wAdr == ADDR_OPMODE) opS <= hwdata;
      if (wPend && wAdr == ADDR_ASSIGN) asgS <= hwdata;
      if (wPend && wAdr == ADDR_INT_MASK) maskS <= hwdata[0];
    end
  end
  // raw comparator run length, saturating so a long excursion cannot wrap
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ocRun <= 14'h0000;
    else if (!overcurrentCompare) ocRun <= 14'h0000;
    else if (ocRun != 14'h3fff) ocRun <= ocRun + 14'h0001;
  end
  always_comb begin
    seqV = {seq_enable_extreg, seq_enable_switch, seq_enable_linreg, seq_enable_buck};
    dbnc = ctrlS[1] ? DEBOUNCE_LONG_CYC : DEBOUNCE_SHORT_CYC;
    for (int i = 0; i < 4; i++) begin
      enE[i] = (opS[2*i +: 2] != 2'h0) && !(asgS[i] && !seqV[i]);
      lpE[i] = enE[i] && (opS[2*i +: 2] == 2'h2 ||
        (opS[2*i +: 2] == 2'h1 && !asgS[i] && ctrlS[0]));
    end
    for (int j = 0; j < 3; j++) swE[j] = asgS[4+j] ? seqV[4+j] : opS[8+j];
    for (int k = 0; k < 2; k++) exE[k] = asgS[7+k] ? seqV[7+k] ^ opS[12+k] : opS[12+k];
    vsE = !asgS[2] && opS[5:4] == 2'h1 && ctrlS[0] && ctrlS[5];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  reg_enable_a: assert property ({linreg_enable_out, buckEnableOut} == $past(enE))
    else $error("regulator enable wrong");
  reg_lowpwr_a: assert property ({linreg_low_power_en, buck_low_power_en} == $past(lpE))
    else $error("regulator low power wrong");
  sleep_vscale_a: assert property (third_buck_sleep_vscale == $past(vsE))
    else $error("sleep voltage scaling wrong");
  switch_enable_a: assert property (switch_enable_out == $past(swE))
    else $error("switch enable wrong");
  extreg_pin_a: assert property (extreg_enable_pin == $past(exE))
    else $error("external enable pin wrong");
  ctrl_copy_a: assert property ({holdupEnableOut, overcurrent_threshold_sel} == $past({ctrlS[4], ctrlS[3:2]}))
    else $error("holdup or threshold copy wrong");
  pdown_debounce_a: assert property (powerDownReq |-> ocRun >= dbnc - 2 && ocRun <= dbnc + 8)
    else $error("power-down outside debounce window");
  pdown_mask_a: assert property (powerDownReq |-> !$past(maskS) ##1 !powerDownReq)
    else $error("power-down while masked or too long");
  irq_mask_a: assert property (irq |-> !$past(maskS))
    else $error("interrupt while masked");
  pdown_irq_a: assert property (powerDownReq |-> ##[0:2] irq)
    else $error("no interrupt with power-down");
endmodule

bind rpm_resource_power_mode_decode rpm_resource_power_mode_decode_props i_props (.*);

// ==== rpm_seq_model.sv ====
`timescale 1ns/1ps
// sequencer enables and comparator level, changing just after an edge
module rpm_seq_model (
  input wire logic ref_clk,
  input wire logic [8:0] seqReq,
  input wire logic ocReq,
  output logic [8:0] seqAll,
  output logic ocLevel
);
  initial seqAll = 9'h000;
  initial ocLevel = 1'b0;
  always @(posedge ref_clk) begin
    seqAll <= seqReq;
    ocLevel <= ocReq;
  end
endmodule
